/* File: logic/ilr_input_limit_regs.v */
// Input current and input voltage limit register group with byte register port
//
// Functional notes
// RULE1 - Host current cap is bits 6..0 at 0x0F, weights 3200 mA down to 50 mA.
// RULE2 - After reset the host current cap holds bit 6 only, about 3.3 A.
// RULE3 - Adapter removal returns the host current cap to its default without a write.
// RULE4 - Host writes zeros to reserved upper bits; a one makes the write invalid.
// RULE5 - Reserved low bytes at 0x0E and bits 5..0 at 0x0A ignore writes.
// RULE6 - Effective cap shows the limit in force, from host or optimizer.
// RULE7 - After an optimizer run, 0x25/0x24 report the regulation limit used.
// RULE8 - Effective cap is read-only bits 6..0 at 0x25, resetting to zero.
// RULE9 - Effective cap readback carries a 50 mA offset; code zero means 50 mA.
// RULE10 - Host programs the voltage floor as one 16-bit command over 0x0B/0x0A.
// RULE11 - Voltage floor: six bits at 0x0B[5:0], two at 0x0A[7:6], 8192..64 mV.
// RULE12 - A fixed 3.2 V offset is added to the voltage floor code.
// RULE13 - Before programming, the floor sits 1.28 V below no-load input voltage.
// RULE14 - Input voltage below the floor enters power management, cutting charge current.
// RULE15 - Host cap writes update the effective cap unless an optimizer result overrides.
`timescale 1ns/1ps
`include "ilr_defs.vh"

module ilr_input_limit_regs #(
    parameter CAP_W   = `ILR_CAP_W,
    parameter FLOOR_W = `ILR_FLOOR_W,
    parameter MA_W    = `ILR_MA_W,
    parameter MV_W    = `ILR_MV_W
) (
    // Clock and reset
    input  wire               clk,
    input  wire               reset,
    // Byte register port from the serial interface core
    input  wire [7:0]         reg_addr,
    input  wire [7:0]         reg_wdata,
    input  wire               reg_write,
    input  wire               reg_read,
    output reg  [7:0]         reg_rdata,
    output reg                reg_rdata_valid,
    output reg                invalid_write,
    // Adapter detect pin, asynchronous
    input  wire               adapter_present,
    // Input current optimizer result, same clock
    input  wire               optimizer_done,
    input  wire [CAP_W-1:0]   optimizer_cap,
    // Measured input bus voltages, same clock
    input  wire [MV_W-1:0]    input_bus_voltage_mv,
    input  wire [MV_W-1:0]    no_load_voltage_mv,
    // Limits to the regulation loops
    output reg  [CAP_W-1:0]   host_current_cap,
    output reg  [CAP_W-1:0]   effective_current_cap,
    output reg  [MA_W-1:0]    effective_current_ma,
    output reg  [MV_W-1:0]    source_voltage_floor_mv,
    output reg                dynamic_power_management,
    output reg                charge_current_cut
);

    // Adapter detect synchroniser
    reg               adapter_meta;
    reg               adapter_sync;
    reg               adapter_prev;
    wire              adapter_removed;

    // Register contents
    reg [FLOOR_W-1:0] source_voltage_floor;
    reg [1:0]         floor_low_pending;
    reg               floor_programmed;
    reg               optimizer_override;

    // Write decode
    wire              wr_floor_low;
    wire              wr_floor_high;
    wire              wr_host_high;
    wire              wr_ro;
    wire              bad_reserved;
    wire              host_rsvd_bad;
    wire              floor_rsvd_bad;
    wire              host_write_ok;
    wire              floor_write_ok;
    reg  [7:0]        next_rdata;

    // Monitor results
    wire [MV_W-1:0]   mon_threshold_mv;
    wire              mon_power_mgmt;

    // Cap code to milliamps, offset included
    function [MA_W-1:0] cap_to_ma;
        input [CAP_W-1:0] code;
        begin
            cap_to_ma = `ILR_CAP_OFFSET_MA
                      + ({{(MA_W-CAP_W){1'b0}}, code} * `ILR_CAP_LSB_MA);
        end
    endfunction

    // Reserved-bit test shared by both limit bytes that can refuse a write
    function reserved_set;
        input [7:0] data;
        input [7:0] mask;
        begin
            reserved_set = ((data & mask) != `ILR_RDATA_ZERO);
        end
    endfunction

    // Read-only bytes of this group; writes there are dropped without a flag
    function is_ro_byte;
        input [7:0] addr;
        begin
            is_ro_byte = (addr == `ILR_ADDR_HOST_CAP_LOW)
                      || (addr == `ILR_ADDR_EFF_CAP_LOW)
                      || (addr == `ILR_ADDR_EFF_CAP_HIGH);
        end
    endfunction

    // Sixteen-bit floor command: high byte bits 5..0 above the two staged low bits
    function [FLOOR_W-1:0] floor_commit;
        input [7:0]                     high_byte;
        input [`ILR_FLOOR_LOW_BITS-1:0] staged;
        begin
            floor_commit = {high_byte[`ILR_FLOOR_HIGH_BITS-1:0], staged};
        end
    endfunction

    // Two flops before any logic sees the adapter pin
    always @(posedge clk or posedge reset) begin
        if (reset) begin
            adapter_meta <= 1'b0;
            adapter_sync <= 1'b0;
        end else begin
            adapter_meta <= adapter_present;
            adapter_sync <= adapter_meta;
        end
    end

    // Resets to absent, so an adapter already present at power-up is no removal
    always @(posedge clk or posedge reset) begin
        if (reset) begin
            adapter_prev <= 1'b0;
        end else begin
            adapter_prev <= adapter_sync;
        end
    end

    assign adapter_removed = adapter_prev & ~adapter_sync; // RULE3

    assign wr_floor_low  = reg_write && (reg_addr == `ILR_ADDR_FLOOR_LOW);
    assign wr_floor_high = reg_write && (reg_addr == `ILR_ADDR_FLOOR_HIGH);
    assign wr_host_high  = reg_write && (reg_addr == `ILR_ADDR_HOST_CAP_HIGH);
    assign wr_ro         = reg_write && is_ro_byte(reg_addr);

    // Reserved upper bits set make the whole byte write void
    assign host_rsvd_bad  = wr_host_high
                         && reserved_set(reg_wdata, `ILR_CAP_RSVD_MASK); // RULE4
    assign floor_rsvd_bad = wr_floor_high
                         && reserved_set(reg_wdata, `ILR_FLOOR_HIGH_RSVD); // RULE4
    assign bad_reserved   = host_rsvd_bad || floor_rsvd_bad;

    // Accepted writes only; a refused byte leaves the register as it was
    assign host_write_ok  = wr_host_high && !host_rsvd_bad;
    assign floor_write_ok = wr_floor_high && !floor_rsvd_bad;

    // Host current cap
    always @(posedge clk or posedge reset) begin
        if (reset) begin
            host_current_cap <= `ILR_HOST_CAP_RESET; // RULE2
        end else if (adapter_removed) begin
            // Removal wins over a write in the same cycle: the source is gone
            host_current_cap <= `ILR_HOST_CAP_RESET; // RULE3
        end else if (host_write_ok) begin
            host_current_cap <= reg_wdata[CAP_W-1:0]; // RULE1
        end
    end

    // Effective cap and optimizer ownership
    always @(posedge clk or posedge reset) begin
        if (reset) begin
            effective_current_cap <= `ILR_EFF_CAP_RESET; // RULE8
            optimizer_override    <= 1'b0;
        end else if (optimizer_done) begin
            effective_current_cap <= optimizer_cap; // RULE6 RULE7
            optimizer_override    <= 1'b1;
        end else if (adapter_removed) begin
            // New source needs a fresh optimizer run; the host default rules again
            effective_current_cap <= `ILR_HOST_CAP_RESET; // RULE3 RULE6
            optimizer_override    <= 1'b0;
        end else if (host_write_ok && !optimizer_override) begin
            effective_current_cap <= reg_wdata[CAP_W-1:0]; // RULE15
        end
    end

    always @(posedge clk or posedge reset) begin
        if (reset) begin
            effective_current_ma <= `ILR_CAP_OFFSET_MA;
        end else begin
            effective_current_ma <= cap_to_ma(effective_current_cap); // RULE9
        end
    end

    // Low byte is only staged: the threshold must not move on half a command
    always @(posedge clk or posedge reset) begin
        if (reset) begin
            floor_low_pending <= 2'b00;
        end else if (wr_floor_low) begin
            // Bits 5..0 dropped here
            floor_low_pending <= reg_wdata[7:`ILR_FLOOR_LOW_SHIFT]; // RULE5
        end
    end

    // Voltage floor is taken as a whole when the high byte lands
    always @(posedge clk or posedge reset) begin
        if (reset) begin
            source_voltage_floor <= `ILR_FLOOR_RESET;
        end else if (floor_write_ok) begin
            source_voltage_floor <= floor_commit(reg_wdata, floor_low_pending); // RULE10 RULE11
        end
    end

    // A new source falls back to the default floor until the host programs it
    always @(posedge clk or posedge reset) begin
        if (reset) begin
            floor_programmed <= 1'b0;
        end else if (floor_write_ok) begin
            floor_programmed <= 1'b1; // RULE13
        end else if (adapter_removed) begin
            floor_programmed <= 1'b0;
        end
    end

    ilr_floor_monitor #(
        .FLOOR_W (FLOOR_W),
        .MV_W    (MV_W)
    ) u_floor_monitor (
        .clk                      (clk),
        .reset                    (reset),
        .floor_code               (source_voltage_floor),
        .floor_programmed         (floor_programmed),
        .input_bus_voltage_mv     (input_bus_voltage_mv),
        .no_load_voltage_mv       (no_load_voltage_mv),
        .threshold_mv             (mon_threshold_mv),
        .dynamic_power_management (mon_power_mgmt)
    );

    // Output flops: every limit leaves this block straight from a register
    always @(posedge clk or posedge reset) begin
        if (reset) begin
            source_voltage_floor_mv <= {MV_W{1'b0}};
        end else begin
            source_voltage_floor_mv <= mon_threshold_mv; // RULE12 RULE13
        end
    end

    // Both loops see one flag, so charge is never cut without power management
    always @(posedge clk or posedge reset) begin
        if (reset) begin
            dynamic_power_management <= 1'b0;
            charge_current_cut       <= 1'b0;
        end else begin
            dynamic_power_management <= mon_power_mgmt; // RULE14
            charge_current_cut       <= mon_power_mgmt; // RULE14
        end
    end

    // Read mux: reserved bits read as zero, unmapped offsets read zero
    always @* begin
        case (reg_addr)
            `ILR_ADDR_FLOOR_LOW: begin
                next_rdata = {source_voltage_floor[`ILR_FLOOR_LOW_BITS-1:0], 6'b00_0000};
            end
            `ILR_ADDR_FLOOR_HIGH: begin
                next_rdata = {2'b00, source_voltage_floor[FLOOR_W-1:`ILR_FLOOR_LOW_BITS]};
            end
            `ILR_ADDR_HOST_CAP_HIGH: begin
                next_rdata = {1'b0, host_current_cap};
            end
            `ILR_ADDR_EFF_CAP_HIGH: begin
                next_rdata = {1'b0, effective_current_cap}; // RULE7 RULE8
            end
            `ILR_ADDR_HOST_CAP_LOW,
            `ILR_ADDR_EFF_CAP_LOW: begin
                next_rdata = `ILR_RDATA_ZERO; // RULE5
            end
            default: begin
                next_rdata = `ILR_RDATA_ZERO;
            end
        endcase
    end

    // Read data holds until the next read so a slow core can fetch it late
    always @(posedge clk or posedge reset) begin
        if (reset) begin
            reg_rdata       <= `ILR_RDATA_ZERO;
            reg_rdata_valid <= 1'b0;
        end else begin
            reg_rdata_valid <= reg_read;
            if (reg_read) begin
                reg_rdata <= next_rdata;
            end
        end
    end

    // Writes to read-only bytes are silently dropped, not flagged
    always @(posedge clk or posedge reset) begin
        if (reset) begin
            invalid_write <= 1'b0;
        end else begin
            invalid_write <= bad_reserved && !wr_ro; // RULE4
        end
    end

endmodule

/* File: logic/ilr_defs.vh */
// Register map, reset values and scaling constants of the input limit registers
`ifndef ILR_DEFS_VH
`define ILR_DEFS_VH

// Register offsets
`define ILR_ADDR_FLOOR_LOW      8'h0A
`define ILR_ADDR_FLOOR_HIGH     8'h0B
`define ILR_ADDR_HOST_CAP_LOW   8'h0E
`define ILR_ADDR_HOST_CAP_HIGH  8'h0F
`define ILR_ADDR_EFF_CAP_LOW    8'h24
`define ILR_ADDR_EFF_CAP_HIGH   8'h25

// Field layout
`define ILR_CAP_W               7
`define ILR_FLOOR_W             8
`define ILR_CAP_RSVD_MASK       8'h80
`define ILR_FLOOR_HIGH_RSVD     8'hC0
`define ILR_FLOOR_LOW_SHIFT     6
`define ILR_FLOOR_HIGH_BITS     6
`define ILR_FLOOR_LOW_BITS      2

// Reset values
`define ILR_HOST_CAP_RESET      7'h40
`define ILR_EFF_CAP_RESET       7'h00
`define ILR_FLOOR_RESET         8'h00
`define ILR_RDATA_ZERO          8'h00

// Scaling: current in mA, voltage in mV
`define ILR_CAP_LSB_MA          13'h0032
`define ILR_CAP_OFFSET_MA       13'h0032
`define ILR_FLOOR_LSB_MV        16'h0040
`define ILR_FLOOR_OFFSET_MV     16'h0C80
`define ILR_FLOOR_DEFAULT_DROP  16'h0500
`define ILR_MA_W                13
`define ILR_MV_W                16

`endif

/* File: logic/ilr_floor_monitor.v */
// Input voltage floor threshold and dynamic power management comparator
`timescale 1ns/1ps
`include "ilr_defs.vh"

module ilr_floor_monitor #(
    parameter FLOOR_W = `ILR_FLOOR_W,
    parameter MV_W    = `ILR_MV_W
) (
    // Clock and reset
    input  wire               clk,
    input  wire               reset,
    // Floor setting
    input  wire [FLOOR_W-1:0] floor_code,
    input  wire               floor_programmed,
    // Measured voltages
    input  wire [MV_W-1:0]    input_bus_voltage_mv,
    input  wire [MV_W-1:0]    no_load_voltage_mv,
    // Results
    output reg  [MV_W-1:0]    threshold_mv,
    output reg                dynamic_power_management
);

    reg [MV_W-1:0] next_threshold_mv;

    // Code to millivolts with the fixed offset
    function [MV_W-1:0] floor_to_mv;
        input [FLOOR_W-1:0] code;
        begin
            floor_to_mv = `ILR_FLOOR_OFFSET_MV
                        + ({{(MV_W-FLOOR_W){1'b0}}, code} * `ILR_FLOOR_LSB_MV);
        end
    endfunction

    always @* begin
        if (floor_programmed) begin
            next_threshold_mv = floor_to_mv(floor_code); // RULE11 RULE12
        end else if (no_load_voltage_mv > `ILR_FLOOR_DEFAULT_DROP) begin
            next_threshold_mv = no_load_voltage_mv - `ILR_FLOOR_DEFAULT_DROP; // RULE13
        end else begin
            // A dead source must not wrap round to a huge threshold
            next_threshold_mv = {MV_W{1'b0}};
        end
    end

    always @(posedge clk or posedge reset) begin
        if (reset) begin
            threshold_mv             <= {MV_W{1'b0}};
            dynamic_power_management <= 1'b0;
        end else begin
            threshold_mv             <= next_threshold_mv;
            // Compare against last cycle's threshold: one cycle of lag, no glitch path
            dynamic_power_management <= (input_bus_voltage_mv < threshold_mv); // RULE14
        end
    end

endmodule

/* File: test/ilr_asserts.sv */
// Concurrent checks on the input limit register group, bound to its top module
`timescale 1ns/1ps
module ilr_checker (
    // Clock and reset
    input wire        clk,
    input wire        reset,
    // Register port
    input wire [7:0]  reg_addr,
    input wire [7:0]  reg_wdata,
    input wire        reg_write,
    input wire        reg_read,
    input wire [7:0]  reg_rdata,
    input wire        reg_rdata_valid,
    input wire        invalid_write,
    // Optimizer and measured voltage
    input wire        optimizer_done,
    input wire [6:0]  optimizer_cap,
    input wire [15:0] input_bus_voltage_mv,
    // Limits in force
    input wire [6:0]  host_current_cap,
    input wire [6:0]  effective_current_cap,
    input wire [12:0] effective_current_ma,
    input wire [15:0] source_voltage_floor_mv,
    input wire        dynamic_power_management,
    input wire        charge_current_cut
);
    default clocking @(posedge clk);
    endclocking
    default disable iff (reset);
    wire under_floor = input_bus_voltage_mv < source_voltage_floor_mv;
    sequence s_lo;
        reg_write && reg_addr == 8'h0A;
    endsequence
    sequence s_hi;
        reg_write && reg_addr == 8'h0B && reg_wdata[7:6] == 2'h0;
    endsequence
    AST_RD_HOST: assert property (reg_read && reg_addr == 8'h0F |=>
        reg_rdata_valid && reg_rdata == {1'b0, $past(host_current_cap)})
        else $error("host cap readback mismatch");
    AST_WR_HOST: assert property (reg_write && reg_addr == 8'h0F && !reg_wdata[7] |=>
        host_current_cap == $past(reg_wdata[6:0])) else $error("host cap not written");
    AST_INVALID: assert property (reg_write && ((reg_addr == 8'h0F && reg_wdata[7]) ||
        (reg_addr == 8'h0B && reg_wdata[7:6] != 2'h0)) |=> invalid_write)
        else $error("reserved bit write not refused");
    AST_RD_RSVD: assert property (reg_read && (reg_addr == 8'h0E || reg_addr == 8'h24)
        |=> reg_rdata == 8'h00) else $error("reserved byte reads nonzero");
    AST_RD_EFF: assert property (reg_read && reg_addr == 8'h25 |=>
        reg_rdata == {1'b0, $past(effective_current_cap)}) else $error("effective cap readback");
    AST_OPT: assert property (optimizer_done |=>
        effective_current_cap == $past(optimizer_cap)) else $error("optimizer cap not in force");
    AST_MA: assert property (effective_current_ma ==
        13'h0032 + 13'h0032 * $past(effective_current_cap)) else $error("cap in mA wrong");
    AST_CUT: assert property (charge_current_cut == dynamic_power_management)
        else $error("charge cut differs from power management");
    AST_PWR_MGMT_ON: assert property (under_floor [*4] |-> dynamic_power_management)
        else $error("power management not entered");
    AST_PWR_MGMT_OFF: assert property (!under_floor [*4] |-> !dynamic_power_management)
        else $error("power management without sag");
    AST_FLOOR: assert property (s_lo ##1 s_hi |-> ##3 source_voltage_floor_mv ==
        16'h0C80 + 16'h0040 * {$past(reg_wdata[5:0], 3), $past(reg_wdata[7:6], 4)})
        else $error("voltage floor threshold wrong");
endmodule
bind ilr_input_limit_regs ilr_checker u_checker (.*);

/* File: test/ilr_host_model.sv */
// Host model that drives the byte register port as the serial core would
`timescale 1ns/1ps
module ilr_host_model (
    // Clock
    input wire         clk,
    // Register port
    output logic [7:0] reg_addr,
    output logic [7:0] reg_wdata,
    output logic       reg_write,
    output logic       reg_read,
    input wire [7:0]   reg_rdata,
    input wire         reg_rdata_valid
);
    initial begin
        {reg_addr, reg_wdata, reg_write, reg_read} = 18'h0_0000;
    end
    // Released lines flip so a stale address or byte never looks current
    task automatic idle();
        @(negedge clk);
        {reg_write, reg_read} = 2'h0;
        reg_addr = ~reg_addr;
        reg_wdata = ~reg_wdata;
    endtask
    // Reserved bits are sent as the caller gives them; callers send zeros unless testing refusal or ignored bits
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        reg_addr = a;
        reg_wdata = d;
        reg_write = 1'b1;
    endtask
    // The floor always goes as one low-then-high pair
    task automatic fl(input logic [7:0] hi, input logic [7:0] lo);
        wr(8'h0A, lo);
        wr(8'h0B, hi);
        idle();
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge clk);
        reg_addr = a;
        reg_write = 1'b0;
        reg_read = 1'b1;
        idle();
        d = (reg_rdata_valid === 1'b1) ? reg_rdata : 8'hxx;
    endtask
endmodule

/* File: test/tb.sv */
// Self-checking bench for the input limit register group
`timescale 1ns/1ps
module tb;
    logic        clk = 1'b0;
    logic        reset = 1'b1;
    logic        adapter_present = 1'b1;
    logic        optimizer_done = 1'b0;
    logic [6:0]  optimizer_cap = 7'h00;
    logic [15:0] input_bus_voltage_mv = 16'h1388;
    logic [15:0] no_load_voltage_mv = 16'h1388;
    wire [7:0]   reg_addr, reg_wdata, reg_rdata;
    wire         reg_write, reg_read, reg_rdata_valid, invalid_write;
    wire [6:0]   host_current_cap, effective_current_cap;
    wire [12:0]  effective_current_ma;
    wire [15:0]  source_voltage_floor_mv;
    wire         dynamic_power_management, charge_current_cut;
    logic [7:0]  rv;
    logic [7:0]  codes [3] = '{8'h00, 8'h0A, 8'h7F};
    int          n_errors = 0;
    int          checks_done = 0;
    always #5 clk = ~clk;
    ilr_input_limit_regs dut (.*);
    ilr_host_model host (.*);
    task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic chk_val(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
        host.rd(a, rv);
        chk_reg(rv, exp);
    endtask
    task automatic t_reset_values();
        chk_val(16'(host_current_cap), 16'h0040);
        chk_val(16'(effective_current_ma), 16'h0032);
        rdc(8'h0F, 8'h40);
        rdc(8'h25, 8'h00);
        rdc(8'h24, 8'h00);
        rdc(8'h30, 8'h00);
        $display("test reset_values done");
    endtask
    task automatic t_host_cap();
        foreach (codes[i]) begin
            host.wr(8'h0F, codes[i]);
            host.idle();
            @(negedge clk);
            chk_val(16'(effective_current_cap), 16'(codes[i]));
            chk_val(16'(effective_current_ma), 16'h0032 + 16'h0032 * codes[i]);
            rdc(8'h0F, codes[i]);
        end
        host.wr(8'h0F, 8'hC1);
        host.idle();
        chk_val(16'(invalid_write), 16'h0001);
        rdc(8'h0F, 8'h7F);
        host.wr(8'h0E, 8'hFF);
        host.wr(8'h25, 8'h01);
        host.idle();
        rdc(8'h0E, 8'h00);
        rdc(8'h25, 8'h7F);
        $display("test host_cap done");
    endtask
    task automatic t_floor();
        chk_val(source_voltage_floor_mv, 16'h0E88);
        host.fl(8'h3F, 8'hFF);
        repeat (3) @(negedge clk);
        chk_val(source_voltage_floor_mv, 16'h4C40);
        rdc(8'h0A, 8'hC0);
        rdc(8'h0B, 8'h3F);
        host.wr(8'h0B, 8'h40);
        host.idle();
        chk_val(16'(invalid_write), 16'h0001);
        host.fl(8'h00, 8'h00);
        repeat (3) @(negedge clk);
        chk_val(source_voltage_floor_mv, 16'h0C80);
        input_bus_voltage_mv = 16'h0C7F;
        repeat (4) @(negedge clk);
        chk_val(16'(dynamic_power_management), 16'h0001);
        input_bus_voltage_mv = 16'h0C80;
        repeat (4) @(negedge clk);
        chk_val(16'(charge_current_cut), 16'h0000);
        input_bus_voltage_mv = 16'h1388;
        $display("test floor done");
    endtask
    task automatic t_optimizer();
        @(negedge clk);
        optimizer_cap = 7'h15;
        optimizer_done = 1'b1;
        @(negedge clk);
        optimizer_done = 1'b0;
        chk_val(16'(effective_current_cap), 16'h0015);
        host.wr(8'h0F, 8'h30);
        host.idle();
        chk_val(16'(host_current_cap), 16'h0030);
        rdc(8'h25, 8'h15);
        $display("test optimizer done");
    endtask
    task automatic t_removal();
        @(negedge clk);
        adapter_present = 1'b0;
        repeat (6) @(negedge clk);
        chk_val(16'(host_current_cap), 16'h0040);
        chk_val(16'(effective_current_cap), 16'h0040);
        chk_val(source_voltage_floor_mv, 16'h0E88);
        adapter_present = 1'b1;
        $display("test removal done");
    endtask
    task automatic end_of_test();
        $display("checks %0d errors %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    initial begin
        repeat (4) @(negedge clk);
        reset = 1'b0;
        t_reset_values();
        t_host_cap();
        t_floor();
        t_optimizer();
        t_removal();
        end_of_test();
    end
    // Under a hundred cycles are needed; this is far beyond that
    initial begin
        #100000;
        n_errors++;
        end_of_test();
    end
endmodule
